// file: rtl/fsp_pkg.sv
// package: register map, field layout, codes and timing for the flash sequencer
package fsp_pkg;
    // ****************************************************************
    // register byte offsets (apb, one word each)
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_OPSEL  = 8'h04;
    localparam logic [7:0] OFS_ADDRH  = 8'h08;
    localparam logic [7:0] OFS_ADDRL  = 8'h0c;
    localparam logic [7:0] OFS_DATA   = 8'h10;
    localparam logic [7:0] OFS_TRIG   = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    // ****************************************************************
    // control register fields
    // ****************************************************************
    localparam int         CTRL_EN_BIT   = 7;
    localparam int         CTRL_BOOT_BIT = 6;
    localparam int         CTRL_SRST_BIT = 5;
    localparam logic [7:0] CTRL_RST      = 8'h00;
    localparam logic [2:0] TIMING_11M    = 3'h3;
    // ****************************************************************
    // operation codes and trigger values
    // ****************************************************************
    localparam logic [2:0] OP_STANDBY = 3'h0;
    localparam logic [2:0] OP_READ    = 3'h1;
    localparam logic [2:0] OP_PROG    = 3'h2;
    localparam logic [2:0] OP_ERASE   = 3'h3;
    localparam logic [7:0] TRIG_FIRST = 8'h46;
    localparam logic [7:0] TRIG_SECOND= 8'hb9;
    localparam logic [7:0] ERASED     = 8'hff;
    // ****************************************************************
    // array geometry and timing
    // ****************************************************************
    localparam int         PAGE_BYTES = 512;
    localparam int         CLK_MHZ    = 50;
    localparam int         OP_TIME_NS = 200;
    localparam int         OP_CYCLES  = (OP_TIME_NS * CLK_MHZ + 999) / 1000;
    typedef enum logic [1:0] {FSP_IDLE, FSP_ERASE, FSP_ACCESS, FSP_DONE} fsp_state_t;
endpackage

// file: rtl/fsp_array.sv
// flash cell array model held in flip-flops
module fsp_array
    import fsp_pkg::*;
#(
    parameter int AW = 10
) (
    input  wire logic          clk_i,
    input  wire logic          reset_i,
    input  wire logic          ce_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic          erase_i,
    input  wire logic          prog_i,
    input  wire logic [7:0]    wdata_i,
    output logic      [7:0]    rdata_o
);
    localparam int DEPTH = 1 << AW;
    logic [7:0] mem_r [DEPTH];
    if (AW < 9) begin : g_bad_aw
        $error("fsp_array: address width below one page");
    end
    assign rdata_o = mem_r[addr_i];
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_cell
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    mem_r[g] <= ERASED;
                end else if (ce_i) begin
                    // whole page to all ones
                    if (erase_i && (g / PAGE_BYTES) == int'(addr_i) / PAGE_BYTES) begin
                        mem_r[g] <= ERASED;
                    end else if (prog_i && g == int'(addr_i)) begin
                        mem_r[g] <= mem_r[g] & wdata_i;
                    end
                end
            end
        end
    endgenerate
endmodule

// file: rtl/fsp_ctrl.sv
// flash self-programming controller: apb registers, trigger, stall, boot
//
// How it works
// - op code 03h erases the page addressed by the address pair.
// - op code 02h programs the data byte at the address pair.
// - op code 01h reads the addressed byte into the data register.
// - an operation starts only after 46h then b9h to trigger register.
// - cpu stall output stays high until the operation finishes.
// - interrupts are held pending while stalled.
// - pending interrupts still active are released after completion.
// - addresses past the data region end ignore the trigger.
// - with a loader boot option set, power-on starts in the loader region.
// - without boot options, loader entered only through software reset.
// - on soft reset boot-select bit picks loader or application.
// - loader fetches are offset by the loader start address.
// - low-voltage lock blocks writes while regulator is below 2.4 V.
// - erase sets all 512 bytes of the page to ff.
// - programming only clears bits; only erase returns ff.
//
// Implementation choices: the APB interface to the registers and the register addresses.
module fsp_ctrl
    import fsp_pkg::*;
#(
    parameter int              AW          = 10,
    parameter logic [AW-1:0]   DATA_LAST   = 10'h37f,
    parameter logic [15:0]     LOADER_BASE = 16'hf000,
    parameter int              NIRQ        = 4
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic             ce_i,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             power_up_loader_boot_i,
    input  wire logic             alt_power_up_loader_boot_i,
    input  wire logic             low_voltage_write_lock_i,
    input  wire logic             regulator_low_i,
    input  wire logic [15:0]      fetch_addr_i,
    output logic      [15:0]      fetch_addr_o,
    input  wire logic [NIRQ-1:0]  irq_req_i,
    output logic      [NIRQ-1:0]  irq_o,
    output logic                  cpu_stall_o,
    output logic                  soft_reset_o,
    output logic                  in_loader_o
);
    if (NIRQ < 1 || AW < 9 || AW > 16) begin : g_bad_param
        $error("fsp_ctrl: bad parameter");
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [7:0]    flash_ctrl_reg_r;
    logic [2:0]    flash_op_select_r;
    logic [7:0]    flash_addr_high_r;
    logic [7:0]    flash_addr_low_r;
    logic [7:0]    flash_data_byte_r;
    logic          armed_r;
    logic          ignored_r;
    logic          in_loader_r;
    logic          boot_done_r;
    logic          soft_reset_r;
    logic [NIRQ-1:0] irq_mask_r;
    fsp_state_t    state_r;
    logic [15:0]   cnt_r;
    logic [2:0]    op_r;
    logic [7:0]    rdata_w;
    logic          arr_erase;
    logic          arr_prog;

    wire        wr_acc  = psel && penable && pwrite && ce_i;
    wire [15:0] addr16  = {flash_addr_high_r, flash_addr_low_r};
    wire        in_range = (addr16 <= 16'(DATA_LAST));
    wire        trig_wr = wr_acc && paddr == OFS_TRIG;
    wire        go      = trig_wr && armed_r && pwdata[7:0] == TRIG_SECOND
                          && flash_ctrl_reg_r[CTRL_EN_BIT] && flash_op_select_r != OP_STANDBY;
    wire        write_ok = !(low_voltage_write_lock_i && regulator_low_i);

    function automatic logic is_mapped(input logic [7:0] a);
        return a == OFS_CTRL || a == OFS_OPSEL || a == OFS_ADDRH || a == OFS_ADDRL
            || a == OFS_DATA || a == OFS_TRIG || a == OFS_STATUS;
    endfunction

    // ****************************************************************
    // apb slave
    // ****************************************************************
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !is_mapped(paddr);

    always_comb begin
        case (paddr)
            OFS_CTRL:   prdata = {24'h0, flash_ctrl_reg_r};
            OFS_OPSEL:  prdata = {29'h0, flash_op_select_r};
            OFS_ADDRH:  prdata = {24'h0, flash_addr_high_r};
            OFS_ADDRL:  prdata = {24'h0, flash_addr_low_r};
            OFS_DATA:   prdata = {24'h0, flash_data_byte_r};
            OFS_STATUS: prdata = {28'h0, in_loader_r, ignored_r, armed_r, cpu_stall_o};
            default:    prdata = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            flash_ctrl_reg_r  <= CTRL_RST;
            flash_op_select_r <= OP_STANDBY;
            flash_addr_high_r <= 8'h00;
            flash_addr_low_r  <= 8'h00;
        end else if (wr_acc) begin
            case (paddr)
                OFS_CTRL:  flash_ctrl_reg_r  <= pwdata[7:0] & 8'he7;
                OFS_OPSEL: flash_op_select_r <= pwdata[2:0];
                OFS_ADDRH: flash_addr_high_r <= pwdata[7:0];
                OFS_ADDRL: flash_addr_low_r  <= pwdata[7:0];
                default:   ;
            endcase
        end
    end

    // ****************************************************************
    // trigger sequence
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            armed_r   <= 1'b0;
            ignored_r <= 1'b0;
        end else if (trig_wr) begin
            armed_r <= (pwdata[7:0] == TRIG_FIRST);
            if (go) begin
                ignored_r <= !in_range;
            end
        end
    end

    // ****************************************************************
    // operation sequencer
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= FSP_IDLE;
            cnt_r   <= 16'h0;
            op_r    <= OP_STANDBY;
        end else if (ce_i) begin
            case (state_r)
                FSP_IDLE: begin
                    if (go && in_range) begin
                        op_r    <= flash_op_select_r;
                        cnt_r   <= 16'(OP_CYCLES);
                        state_r <= FSP_ACCESS;
                    end
                end
                FSP_ACCESS: begin
                    if (cnt_r == 16'h1) begin
                        state_r <= FSP_DONE;
                    end
                    cnt_r <= cnt_r - 16'h1;
                end
                FSP_DONE:  state_r <= FSP_IDLE;
                default:   state_r <= FSP_IDLE;
            endcase
        end
    end

    assign cpu_stall_o = state_r == FSP_ACCESS || state_r == FSP_DONE;
    assign arr_erase   = state_r == FSP_DONE && op_r == OP_ERASE && write_ok;
    assign arr_prog    = state_r == FSP_DONE && op_r == OP_PROG && write_ok;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            flash_data_byte_r <= 8'h00;
        end else if (ce_i) begin
            if (state_r == FSP_DONE && op_r == OP_READ) begin
                flash_data_byte_r <= rdata_w;
            end else if (wr_acc && paddr == OFS_DATA) begin
                flash_data_byte_r <= pwdata[7:0];
            end
        end
    end

    fsp_array #(.AW(AW)) u_array (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .ce_i    (ce_i),
        .addr_i  (addr16[AW-1:0]),
        .erase_i (arr_erase),
        .prog_i  (arr_prog),
        .wdata_i (flash_data_byte_r),
        .rdata_o (rdata_w)
    );

    // ****************************************************************
    // interrupt hold during stall
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            irq_mask_r <= '0;
        end else if (ce_i) begin
            irq_mask_r <= {NIRQ{cpu_stall_o}};
        end
    end
    // live request passes only when not stalled in this cycle or the one before
    assign irq_o = irq_req_i & ~{NIRQ{cpu_stall_o}} & ~irq_mask_r;

    // ****************************************************************
    // boot region selection
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            boot_done_r  <= 1'b0;
            in_loader_r  <= 1'b0;
            soft_reset_r <= 1'b0;
        end else if (ce_i) begin
            soft_reset_r <= 1'b0;
            if (!boot_done_r) begin
                boot_done_r <= 1'b1;
                in_loader_r <= power_up_loader_boot_i || alt_power_up_loader_boot_i;
            end else if (wr_acc && paddr == OFS_CTRL && pwdata[CTRL_SRST_BIT]) begin
                soft_reset_r <= 1'b1;
                in_loader_r  <= pwdata[CTRL_BOOT_BIT];
            end
        end
    end
    assign soft_reset_o = soft_reset_r;
    assign in_loader_o  = in_loader_r;
    assign fetch_addr_o = in_loader_r ? fetch_addr_i + LOADER_BASE : fetch_addr_i;

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_start;
        @(posedge clk_i) disable iff (reset_i) (go && in_range && state_r == FSP_IDLE && ce_i)
            |=> cpu_stall_o;
    endproperty
    a_start: assert property (p_start) else $error("stall missing after trigger");

    property p_nostart;
        @(posedge clk_i) disable iff (reset_i) (state_r == FSP_IDLE && !go) |=> !cpu_stall_o;
    endproperty
    a_nostart: assert property (p_nostart) else $error("stall without trigger");

    property p_range;
        @(posedge clk_i) disable iff (reset_i) (go && !in_range) |=> !cpu_stall_o && ignored_r;
    endproperty
    a_range: assert property (p_range) else $error("out of range trigger ran");

    property p_stall_len;
        @(posedge clk_i) disable iff (reset_i) (ce_i && $rose(cpu_stall_o)) |-> ##[1:1000] !cpu_stall_o;
    endproperty
    a_stall_len: assert property (p_stall_len) else $error("stall never ends");

    property p_irq_hold;
        @(posedge clk_i) disable iff (reset_i) cpu_stall_o |-> irq_o == '0;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq during stall");

    property p_read;
        @(posedge clk_i) disable iff (reset_i) (ce_i && state_r == FSP_DONE && op_r == OP_READ)
            |=> flash_data_byte_r == $past(rdata_w);
    endproperty
    a_read: assert property (p_read) else $error("read data not loaded");

    property p_lock;
        @(posedge clk_i) disable iff (reset_i) (low_voltage_write_lock_i && regulator_low_i)
            |-> !arr_erase && !arr_prog;
    endproperty
    a_lock: assert property (p_lock) else $error("write under low voltage");

    property p_boot;
        @(posedge clk_i) disable iff (reset_i) (ce_i && wr_acc && paddr == OFS_CTRL
            && pwdata[CTRL_SRST_BIT] && boot_done_r) |=> soft_reset_o
            && in_loader_o == $past(pwdata[CTRL_BOOT_BIT]);
    endproperty
    a_boot: assert property (p_boot) else $error("soft reset boot wrong");

    property p_irq_release;
        @(posedge clk_i) disable iff (reset_i)
            (!cpu_stall_o && !$past(cpu_stall_o) && $past(ce_i)) |-> irq_o == irq_req_i;
    endproperty
    a_irq_release: assert property (p_irq_release) else $error("irq not released");

    property p_arm;
        @(posedge clk_i) disable iff (reset_i)
            (trig_wr && pwdata[7:0] == TRIG_FIRST) |=> armed_r;
    endproperty
    a_arm: assert property (p_arm) else $error("first trigger value not taken");

    property p_disarm;
        @(posedge clk_i) disable iff (reset_i)
            (trig_wr && pwdata[7:0] != TRIG_FIRST) |=> !armed_r;
    endproperty
    a_disarm: assert property (p_disarm) else $error("sequence not abandoned");

    property p_powerup;
        @(posedge clk_i) disable iff (reset_i) (ce_i && !boot_done_r) |=> in_loader_o
            == ($past(power_up_loader_boot_i) || $past(alt_power_up_loader_boot_i));
    endproperty
    a_powerup: assert property (p_powerup) else $error("power-up region wrong");

    property p_op_latch;
        @(posedge clk_i) disable iff (reset_i) (ce_i && state_r == FSP_IDLE && go && in_range)
            |=> op_r == $past(flash_op_select_r);
    endproperty
    a_op_latch: assert property (p_op_latch) else $error("operation code not latched");

    property p_srst_pulse;
        @(posedge clk_i) disable iff (reset_i) (ce_i && soft_reset_o) |=> !soft_reset_o;
    endproperty
    a_srst_pulse: assert property (p_srst_pulse) else $error("soft reset pulse too long");

    // stall length watch
    logic [15:0] stall_len_r;
    always_ff @(posedge clk_i) begin
        if (reset_i || !cpu_stall_o) begin
            stall_len_r <= 16'h0;
        end else if (ce_i) begin
            stall_len_r <= stall_len_r + 16'h1;
        end
    end

    property p_stall_max;
        @(posedge clk_i) disable iff (reset_i) cpu_stall_o |-> stall_len_r <= 16'(OP_CYCLES);
    endproperty
    a_stall_max: assert property (p_stall_max) else $error("stall longer than operation");

    // ****************************************************************
    // cover points
    // ****************************************************************
    c_erase: cover property (@(posedge clk_i) arr_erase);
    c_prog:  cover property (@(posedge clk_i) arr_prog);
    c_read:  cover property (@(posedge clk_i) state_r == FSP_DONE && op_r == OP_READ);
    c_srst:  cover property (@(posedge clk_i) soft_reset_o);
    c_skip:  cover property (@(posedge clk_i) go && !in_range);
endmodule

// file: tb/flash_self_programming_ctrl_bench.sv
// self-checking testbench for the flash self-programming controller
module flash_self_programming_ctrl_bench
    import fsp_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // signals and design instance
    // ****************************************************************
    typedef struct packed {
        logic [2:0]  op;
        logic [15:0] addr;
        logic [7:0]  wd;
        logic [15:0] ca;
        logic [7:0]  exp;
        logic        acc;
    } fsp_row_t;
    logic        clk_i;
    logic        reset_i = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        hw_boot = 1'b0, alt_boot = 1'b0, lv_lock = 1'b0, reg_low = 1'b0;
    logic        ce = 1'b1;
    logic [15:0] fetch_addr_i = 16'h0123, fetch_addr_o;
    logic [3:0]  irq_req_i = 4'ha, irq_o;
    logic        cpu_stall_o, soft_reset_o, in_loader_o, stall_q = 1'b0;
    int          failures = 0, checks = 0, cycles = 0, stall_cnt = 0, n;
    fsp_row_t    rows[8] = '{
        '{OP_READ,  16'h0010, 8'h00, 16'h0010, 8'hff, 1'b1},
        '{OP_PROG,  16'h0010, 8'h5a, 16'h0010, 8'h5a, 1'b1},
        '{OP_PROG,  16'h0010, 8'h0f, 16'h0010, 8'h0a, 1'b1},
        '{OP_PROG,  16'h01ff, 8'h33, 16'h01ff, 8'h33, 1'b1},
        '{OP_ERASE, 16'h0000, 8'h00, 16'h01ff, 8'hff, 1'b1},
        '{OP_PROG,  16'h037f, 8'h44, 16'h037f, 8'h44, 1'b1},
        '{OP_PROG,  16'h0380, 8'h12, 16'h0010, 8'hff, 1'b0},
        '{OP_ERASE, 16'h0200, 8'h00, 16'h037f, 8'hff, 1'b1}};

    fsp_ctrl fsp_ctrl_i (.clk_i, .reset_i, .ce_i(ce), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .power_up_loader_boot_i(hw_boot),
        .alt_power_up_loader_boot_i(alt_boot), .low_voltage_write_lock_i(lv_lock),
        .regulator_low_i(reg_low), .fetch_addr_i, .fetch_addr_o, .irq_req_i, .irq_o,
        .cpu_stall_o, .soft_reset_o, .in_loader_o);

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // ****************************************************************
    // checking, bus and sequence tasks
    // ****************************************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    // first trigger value, one other write, second value, then count the stall
    task automatic trig(input logic [7:0] a, input logic [7:0] d, input logic acc);
        wr(OFS_TRIG, TRIG_FIRST);
        wr(a, d);
        stall_cnt = 0;
        wr(OFS_TRIG, TRIG_SECOND);
        n = 0;
        while (cpu_stall_o !== 1'b0 && n < 50) begin
            n++;
            @(posedge clk_i);
        end
        chk("stall cycles", 32'(stall_cnt), acc ? 32'(OP_CYCLES + 1) : 32'h0);
        repeat (2) @(posedge clk_i);
        chk("irq resume", 32'(irq_o), 32'(irq_req_i));
    endtask

    task automatic do_op(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d,
                         input logic acc);
        wr(OFS_OPSEL, {5'h0, op});
        wr(OFS_ADDRH, a[15:8]);
        wr(OFS_ADDRL, a[7:0]);
        trig(OFS_DATA, d, acc);
    endtask

    // stall length, interrupt hold-off and hang limit
    always @(posedge clk_i) begin
        cycles++;
        if (cpu_stall_o === 1'b1) stall_cnt++;
        if (cpu_stall_o === 1'b1 || stall_q) chk("irq held", 32'(irq_o), 32'h0);
        stall_q <= cpu_stall_o === 1'b1;
        if (cycles == 10000) begin
            failures++;
            end_of_test();
        end
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        chk("irq idle", 32'(irq_o), 32'(irq_req_i));
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl reset", rd, 32'h0);
        wr(OFS_CTRL, 8'h9b);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl readback", rd, 32'h83);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 32'(err), 32'h1);
        foreach (rows[i]) begin
            do_op(rows[i].op, rows[i].addr, rows[i].wd, rows[i].acc);
            if (!rows[i].acc) begin
                apb(1'b0, OFS_STATUS, 32'h0);
                chk("ignored flag", 32'(rd[2]), 32'h1);
            end
            do_op(OP_READ, rows[i].ca, 8'h00, 1'b1);
            apb(1'b0, OFS_DATA, 32'h0);
            chk("read back", rd, {24'h0, rows[i].exp});
        end
        trig(OFS_TRIG, 8'h55, 1'b0);
        trig(OFS_ADDRL, 8'h10, 1'b1);
        ce <= 1'b0;
        trig(OFS_ADDRL, 8'h10, 1'b0);
        ce <= 1'b1;
        trig(OFS_CTRL, 8'h03, 1'b0);
        wr(OFS_CTRL, 8'h83);
        lv_lock <= 1'b1;
        reg_low <= 1'b1;
        wr(OFS_OPSEL, {5'h0, OP_PROG});
        wr(OFS_ADDRH, 8'h03);
        wr(OFS_ADDRL, 8'h20);
        wr(OFS_DATA, 8'h00);
        wr(OFS_TRIG, TRIG_FIRST);
        wr(OFS_TRIG, TRIG_SECOND);
        repeat (20) @(posedge clk_i);
        lv_lock <= 1'b0;
        reg_low <= 1'b0;
        do_op(OP_READ, 16'h0320, 8'h00, 1'b1);
        apb(1'b0, OFS_DATA, 32'h0);
        chk("locked write", rd, 32'hff);
        wr(OFS_CTRL, 8'he3);
        n = 0;
        while (soft_reset_o !== 1'b1 && n < 8) begin
            n++;
            @(posedge clk_i);
        end
        chk("soft reset pulse", 32'(soft_reset_o), 32'h1);
        repeat (3) @(posedge clk_i);
        chk("loader select", 32'(in_loader_o), 32'h1);
        chk("fetch offset", 32'(fetch_addr_o), 32'hf123);
        wr(OFS_CTRL, 8'ha3);
        repeat (4) @(posedge clk_i);
        chk("app select", 32'(in_loader_o), 32'h0);
        chk("fetch plain", 32'(fetch_addr_o), 32'h0123);
        for (int i = 0; i < 3; i++) begin
            hw_boot  <= (i == 0);
            alt_boot <= (i == 1);
            reset_i  <= 1'b1;
            repeat (2) @(posedge clk_i);
            reset_i  <= 1'b0;
            repeat (4) @(posedge clk_i);
            chk("power-up region", 32'(in_loader_o), 32'(i < 2));
        end
        end_of_test();
    end
endmodule
